// ==== fbsi_pkg.sv ====
// Purpose: shared constants and types for the fieldbus slave status indicators
// Assumes: 250 MHz system clock, classic wishbone register access
// Notes: lamp timing is given in milliseconds and turned into cycle counts here
package fbsi_pkg;
   // clock rate
   localparam int unsigned CLK_KHZ = 250000;
   // lamp timing in ms
   localparam int unsigned FLASH_ON_MS = 200;
   localparam int unsigned FLASH_OFF_MS = 200;
   localparam int unsigned FLASH_GAP_MS = 1000;
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned FLICKER_HALF_MS = 50;
   localparam int unsigned ACT_HOLD_MS = 100;
   // derived cycle counts
   localparam int unsigned FLASH_ON_CYC = FLASH_ON_MS * CLK_KHZ;
   localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CLK_KHZ;
   localparam int unsigned FLASH_GAP_CYC = FLASH_GAP_MS * CLK_KHZ;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
   localparam int unsigned FLICKER_HALF_CYC = FLICKER_HALF_MS * CLK_KHZ;
   localparam int unsigned ACT_HOLD_CYC = ACT_HOLD_MS * CLK_KHZ;
   // process data limits
   localparam int unsigned PD_MAX_BITS = 2048;
   localparam logic [8:0] PD_MAX_BYTES = 9'h100;
   localparam logic [8:0] PD_SIZE_RST = 9'h020;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PD_SIZE = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_LIMIT = 4'hc;
   // control register fields
   localparam int CTRL_CONNECTED = 0;
   localparam int CTRL_RUN = 1;
   localparam int CTRL_IO_BAD = 2;
   localparam int CTRL_SYNC_PEND = 3;
   localparam int CTRL_IDENTIFY = 4;
   localparam int CTRL_FATAL = 5;
   localparam int CTRL_NO_NAME = 6;
   localparam int CTRL_NO_IP = 7;
   localparam int CTRL_ID_MISMATCH = 8;
   localparam int CTRL_SETUP = 9;
   localparam int CTRL_NETWORK_INIT_PHASE = 10;
   localparam int CTRL_EXCEPTION = 11;
   localparam int CTRL_FW_UPDATE = 12;
   localparam int CTRL_DIAG = 13;
   localparam int CTRL_W = 14;
   localparam logic [13:0] CTRL_RST = 14'h0600;
   // pd size register fields
   localparam int PD_IN_LSB = 0;
   localparam int PD_OUT_LSB = 16;
   // status register fields
   localparam int ST_NET_LSB = 0;
   localparam int ST_MOD_LSB = 2;
   localparam int ST_LINK_GREEN = 4;
   localparam int ST_LINK_OK = 5;
   localparam int ST_MODE_BAD = 6;
   localparam int ST_ACTIVE = 7;
   localparam int ST_SIZE_ERR = 8;

   typedef struct packed {
      logic red;
      logic green;
   } fbsi_lamp_t;
endpackage

// ==== fbsi_flash.sv ====
// Purpose: counted flash pattern generator for one lamp
// Assumes: count_i is steady for whole patterns; a change restarts the pattern
// Notes: count 0 keeps the lamp dark
`timescale 1ns/100ps
module fbsi_flash #(
   parameter int unsigned ON_CYC = fbsi_pkg::FLASH_ON_CYC,
   parameter int unsigned OFF_CYC = fbsi_pkg::FLASH_OFF_CYC,
   parameter int unsigned GAP_CYC = fbsi_pkg::FLASH_GAP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] count_i,
   output logic on_o
);
   typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} fbsi_fl_state_t;
   fbsi_fl_state_t st_reg, st_next;
   logic [31:0] tmr_reg, tmr_next;
   logic [1:0] pul_reg, pul_next;
   logic [1:0] cnt_reg, cnt_next;

   if (ON_CYC < 1 || OFF_CYC < 1 || GAP_CYC < 1)
   begin : g_chk
      $error("flash timing counts must be at least one cycle");
   end

   // short pulses, then a long dark gap, repeated while the count holds [R16]
   always_comb
   begin
      st_next = st_reg;
      tmr_next = tmr_reg;
      pul_next = pul_reg;
      cnt_next = count_i;
      if (count_i != cnt_reg)
      begin
         st_next = (count_i == 2'h0) ? FL_IDLE : FL_ON;
         tmr_next = 32'(ON_CYC - 1);
         pul_next = 2'h1;
      end
      else
      begin
         unique case (st_reg)
            FL_IDLE:
            begin
               tmr_next = 32'h0;
            end
            FL_ON:
            begin
               if (tmr_reg == 32'h0)
               begin
                  st_next = FL_OFF;
                  tmr_next = 32'(OFF_CYC - 1);
               end
               else
                  tmr_next = tmr_reg - 32'h1;
            end
            FL_OFF:
            begin
               if (tmr_reg != 32'h0)
                  tmr_next = tmr_reg - 32'h1;
               else if (pul_reg == cnt_reg)
               begin
                  st_next = FL_GAP;
                  tmr_next = 32'(GAP_CYC - 1);
               end
               else
               begin
                  st_next = FL_ON;
                  tmr_next = 32'(ON_CYC - 1);
                  pul_next = pul_reg + 2'h1;
               end
            end
            FL_GAP:
            begin
               if (tmr_reg == 32'h0)
               begin
                  st_next = FL_ON;
                  tmr_next = 32'(ON_CYC - 1);
                  pul_next = 2'h1;
               end
               else
                  tmr_next = tmr_reg - 32'h1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= FL_IDLE;
         tmr_reg <= 32'h0;
         pul_reg <= 2'h0;
         cnt_reg <= 2'h0;
      end
      else
      begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
         pul_reg <= pul_next;
         cnt_reg <= cnt_next;
      end
   end

   assign on_o = (st_reg == FL_ON);
endmodule

// ==== fbsi_top.sv ====
// Purpose: network, module and link/activity lamp drivers with a wishbone register file
// Assumes: firmware mirrors controller and module state into the control register
// Notes: lamps are dark through reset, which stands in for the unpowered state
//
// Overview of operation
// [R1] network lamp dark without controller connection or power; here fatal, setup errors and identify still light it without connection
// [R2] network lamp steady green when connected and controller runs
// [R3] network lamp one green flash on stop, bad io data or pending sync
// [R4] identify request blinks the network lamp green
// [R5] major fault drives both network and module lamps steady red
// [R6] red flash counts one, two, three for name, address, identity errors
// [R7] module lamp dark while unpowered, in setup or network init phase
// [R8] module lamp steady green after network init, normal operation
// [R9] exception state drives the module lamp steady red
// [R10] firmware update alternates the module lamp red and green
// [R11] link lamp dark without ethernet link
// [R12] link lamp steady green with link and no traffic
// [R13] link lamp flickers green while frames pass
// [R14] input and output process data sizes capped at 2048 bits
// [R15] single port runs 100 Mbit/s full duplex only
// [R16] flashes are counted pulses then a long gap, repeated
// [R17] fatal and exception beat error codes, which beat normal indications
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
module fbsi_top #(
   parameter int unsigned FLASH_ON_CYC = fbsi_pkg::FLASH_ON_CYC,
   parameter int unsigned FLASH_OFF_CYC = fbsi_pkg::FLASH_OFF_CYC,
   parameter int unsigned FLASH_GAP_CYC = fbsi_pkg::FLASH_GAP_CYC,
   parameter int unsigned BLINK_HALF_CYC = fbsi_pkg::BLINK_HALF_CYC,
   parameter int unsigned FLICKER_HALF_CYC = fbsi_pkg::FLICKER_HALF_CYC,
   parameter int unsigned ACT_HOLD_CYC = fbsi_pkg::ACT_HOLD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic link_up_i,
   input wire logic speed_100_i,
   input wire logic full_duplex_i,
   input wire logic frame_i,
   output fbsi_pkg::fbsi_lamp_t network_state_lamp_o,
   output fbsi_pkg::fbsi_lamp_t module_state_lamp_o,
   output logic link_lamp_o
);
   logic [fbsi_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [8:0] pd_in_reg, pd_in_next;
   logic [8:0] pd_out_reg, pd_out_next;
   logic size_err_reg, size_err_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic [31:0] blink_tmr_reg, blink_tmr_next;
   logic blink_reg, blink_next;
   logic [31:0] flk_tmr_reg, flk_tmr_next;
   logic flk_reg, flk_next;
   logic [31:0] act_tmr_reg, act_tmr_next;
   fbsi_pkg::fbsi_lamp_t net_reg, net_next;
   fbsi_pkg::fbsi_lamp_t mod_reg, mod_next;
   logic link_lamp_reg, link_lamp_next;
   logic [1:0] net_cnt;
   logic [1:0] mod_cnt;
   logic net_flash;
   logic mod_flash;
   logic link_ok;
   logic active;
   logic wr_req;
   logic [31:0] wr_word;
   logic [8:0] wr_in;
   logic [8:0] wr_out;
   logic [31:0] status_word;

   if (BLINK_HALF_CYC < 1 || FLICKER_HALF_CYC < 1 || ACT_HOLD_CYC < 1)
   begin : g_chk
      $error("lamp timing counts must be at least one cycle");
   end

   // only a 100 Mbit/s full duplex link counts as up [R15]
   assign link_ok = link_up_i & speed_100_i & full_duplex_i;
   assign active = (act_tmr_reg != 32'h0);
   assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;

   // byte lanes merge into the current register image
   always_comb
   begin
      wr_word = 32'h0;
      unique case (wb_adr_i)
         fbsi_pkg::OFS_CTRL: wr_word = 32'(ctrl_reg);
         fbsi_pkg::OFS_PD_SIZE: wr_word = {7'h0, pd_out_reg, 7'h0, pd_in_reg};
         default: wr_word = 32'h0;
      endcase
      for (int b = 0; b < 4; b++)
      begin
         if (wb_sel_i[b])
            wr_word[8*b +: 8] = wb_dat_i[8*b +: 8];
      end
   end

   assign wr_in = wr_word[fbsi_pkg::PD_IN_LSB +: 9];
   assign wr_out = wr_word[fbsi_pkg::PD_OUT_LSB +: 9];

   assign status_word = {23'h0, size_err_reg, active, link_up_i & ~link_ok, link_ok,
                         link_lamp_reg, mod_reg, net_reg};

   // register file and single-cycle wishbone answer
   always_comb
   begin
      ctrl_next = ctrl_reg;
      pd_in_next = pd_in_reg;
      pd_out_next = pd_out_reg;
      size_err_next = size_err_reg;
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      dat_next = 32'h0;
      if (wr_req)
      begin
         unique case (wb_adr_i)
            fbsi_pkg::OFS_CTRL:
               ctrl_next = wr_word[fbsi_pkg::CTRL_W-1:0];
            fbsi_pkg::OFS_PD_SIZE:
            begin
               // an oversize image is refused whole and flagged [R14]
               if (wr_in > fbsi_pkg::PD_MAX_BYTES || wr_out > fbsi_pkg::PD_MAX_BYTES)
                  size_err_next = 1'b1;
               else
               begin
                  pd_in_next = wr_in;
                  pd_out_next = wr_out;
               end
            end
            fbsi_pkg::OFS_STATUS:
            begin
               if (wb_sel_i[1] && wb_dat_i[fbsi_pkg::ST_SIZE_ERR])
                  size_err_next = 1'b0;
            end
            default:
               ctrl_next = ctrl_reg;
         endcase
      end
      if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg)
      begin
         unique case (wb_adr_i)
            fbsi_pkg::OFS_CTRL: dat_next = 32'(ctrl_reg);
            fbsi_pkg::OFS_PD_SIZE: dat_next = {7'h0, pd_out_reg, 7'h0, pd_in_reg};
            fbsi_pkg::OFS_STATUS: dat_next = status_word;
            fbsi_pkg::OFS_LIMIT: dat_next = 32'(fbsi_pkg::PD_MAX_BITS);
            default: dat_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= fbsi_pkg::CTRL_RST;
         pd_in_reg <= fbsi_pkg::PD_SIZE_RST;
         pd_out_reg <= fbsi_pkg::PD_SIZE_RST;
         size_err_reg <= 1'b0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         pd_in_reg <= pd_in_next;
         pd_out_reg <= pd_out_next;
         size_err_reg <= size_err_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   // free-running blink and flicker phases, activity hold window
   always_comb
   begin
      blink_tmr_next = blink_tmr_reg - 32'h1;
      blink_next = blink_reg;
      if (blink_tmr_reg == 32'h0)
      begin
         blink_tmr_next = 32'(BLINK_HALF_CYC - 1);
         blink_next = ~blink_reg;
      end
      flk_tmr_next = flk_tmr_reg - 32'h1;
      flk_next = flk_reg;
      if (flk_tmr_reg == 32'h0)
      begin
         flk_tmr_next = 32'(FLICKER_HALF_CYC - 1);
         flk_next = ~flk_reg;
      end
      act_tmr_next = active ? act_tmr_reg - 32'h1 : 32'h0;
      if (frame_i & link_ok)
         act_tmr_next = 32'(ACT_HOLD_CYC);
      else if (!link_ok)
         act_tmr_next = 32'h0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         blink_tmr_reg <= 32'h0;
         blink_reg <= 1'b0;
         flk_tmr_reg <= 32'h0;
         flk_reg <= 1'b0;
         act_tmr_reg <= 32'h0;
      end
      else
      begin
         blink_tmr_reg <= blink_tmr_next;
         blink_reg <= blink_next;
         flk_tmr_reg <= flk_tmr_next;
         flk_reg <= flk_next;
         act_tmr_reg <= act_tmr_next;
      end
   end

   // flash counts for each lamp; the highest-priority code wins [R17]
   always_comb
   begin
      net_cnt = 2'h0;
      if (ctrl_reg[fbsi_pkg::CTRL_FATAL])
         net_cnt = 2'h0;
      else if (ctrl_reg[fbsi_pkg::CTRL_NO_NAME])
         net_cnt = 2'h1; // [R6]
      else if (ctrl_reg[fbsi_pkg::CTRL_NO_IP])
         net_cnt = 2'h2; // [R6]
      else if (ctrl_reg[fbsi_pkg::CTRL_ID_MISMATCH])
         net_cnt = 2'h3; // [R6]
      else if (ctrl_reg[fbsi_pkg::CTRL_CONNECTED] && !ctrl_reg[fbsi_pkg::CTRL_IDENTIFY] &&
               (!ctrl_reg[fbsi_pkg::CTRL_RUN] || ctrl_reg[fbsi_pkg::CTRL_IO_BAD] ||
                ctrl_reg[fbsi_pkg::CTRL_SYNC_PEND]))
         net_cnt = 2'h1; // [R3]
      mod_cnt = 2'h0;
      if (ctrl_reg[fbsi_pkg::CTRL_DIAG])
         mod_cnt = 2'h1;
   end

   fbsi_flash #(
      .ON_CYC(FLASH_ON_CYC),
      .OFF_CYC(FLASH_OFF_CYC),
      .GAP_CYC(FLASH_GAP_CYC)
   ) u_net_flash (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .count_i(net_cnt),
      .on_o(net_flash)
   );

   fbsi_flash #(
      .ON_CYC(FLASH_ON_CYC),
      .OFF_CYC(FLASH_OFF_CYC),
      .GAP_CYC(FLASH_GAP_CYC)
   ) u_mod_flash (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .count_i(mod_cnt),
      .on_o(mod_flash)
   );

   // lamp selection
   always_comb
   begin
      net_next = '0;
      if (ctrl_reg[fbsi_pkg::CTRL_FATAL])
         net_next.red = 1'b1; // [R5] [R17]
      // setup errors flash even with no controller connection
      else if (ctrl_reg[fbsi_pkg::CTRL_NO_NAME] || ctrl_reg[fbsi_pkg::CTRL_NO_IP] ||
               ctrl_reg[fbsi_pkg::CTRL_ID_MISMATCH])
         net_next.red = net_flash; // [R6] [R16]
      else if (ctrl_reg[fbsi_pkg::CTRL_IDENTIFY])
         net_next.green = blink_reg; // [R4]
      else if (!ctrl_reg[fbsi_pkg::CTRL_CONNECTED])
         net_next = '0; // [R1]
      else if (net_cnt == 2'h1)
         net_next.green = net_flash; // [R3]
      else
         net_next.green = 1'b1; // [R2]
      mod_next = '0;
      if (ctrl_reg[fbsi_pkg::CTRL_FATAL] || ctrl_reg[fbsi_pkg::CTRL_EXCEPTION])
         mod_next.red = 1'b1; // [R5] [R9] [R17]
      else if (ctrl_reg[fbsi_pkg::CTRL_FW_UPDATE])
      begin
         mod_next.red = blink_reg; // [R10]
         mod_next.green = ~blink_reg;
      end
      else if (ctrl_reg[fbsi_pkg::CTRL_SETUP] || ctrl_reg[fbsi_pkg::CTRL_NETWORK_INIT_PHASE])
         mod_next = '0; // [R7]
      else if (ctrl_reg[fbsi_pkg::CTRL_DIAG])
         mod_next.green = mod_flash;
      else
         mod_next.green = 1'b1; // [R8]
      // dark without link, steady on idle link, flicker on traffic
      if (!link_ok)
         link_lamp_next = 1'b0; // [R11]
      else if (active)
         link_lamp_next = flk_reg; // [R13]
      else
         link_lamp_next = 1'b1; // [R12]
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         net_reg <= '0;
         mod_reg <= '0;
         link_lamp_reg <= 1'b0;
      end
      else
      begin
         net_reg <= net_next;
         mod_reg <= mod_next;
         link_lamp_reg <= link_lamp_next;
      end
   end

   assign wb_dat_o = dat_reg;
   assign wb_ack_o = ack_reg;
   assign network_state_lamp_o = net_reg;
   assign module_state_lamp_o = mod_reg;
   assign link_lamp_o = link_lamp_reg;
endmodule

// ==== fbsi_top_monitor.sv ====
// Purpose: port-level checks for the status lamp block
// Assumes: bench timing parameters 4,4,12,6,2,10
// Notes: lamps lag their cause by one registered cycle
`timescale 1ns/100ps
module fbsi_top_monitor #(
   parameter int unsigned ACT_HOLD_CYC = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic link_up_i,
   input wire logic speed_100_i,
   input wire logic full_duplex_i,
   input wire logic frame_i,
   input wire fbsi_pkg::fbsi_lamp_t network_state_lamp_o,
   input wire fbsi_pkg::fbsi_lamp_t module_state_lamp_o,
   input wire logic link_lamp_o
);
   logic ok;
   logic [15:0] quiet_reg;
   logic [15:0] quiet_next;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   assign ok = link_up_i & speed_100_i & full_duplex_i;
   // cycles since the last frame with a good link; saturates
   always_comb
   begin
      quiet_next = (frame_i || !ok) ? 16'h0000 : quiet_reg + {15'h0000, quiet_reg != 16'hffff};
   end
   always_ff @(posedge clk_i)
   begin
      quiet_reg <= rst_i ? 16'h0000 : quiet_next;
   end
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data outside ack cycle");
   chk_reset_dark: assert property ($past(rst_i) |-> {network_state_lamp_o, module_state_lamp_o, link_lamp_o} == 5'h00)
      else $error("lamp lit right after reset");
   chk_link_dark: assert property (!link_up_i |=> !link_lamp_o)
      else $error("link lamp lit without link");
   chk_mode_bad: assert property (link_up_i && !(speed_100_i && full_duplex_i) |=> !link_lamp_o)
      else $error("link lamp lit in wrong mode");
   chk_link_steady: assert property (int'(quiet_reg) > ACT_HOLD_CYC + 4 |-> link_lamp_o)
      else $error("idle link lamp not steady");
   chk_link_flicker: assert property (ok && frame_i |=> ##[1:6] (!ok || $changed(link_lamp_o)))
      else $error("link lamp not flickering");
   chk_fatal_pair: assert property (network_state_lamp_o.red [*6] |-> module_state_lamp_o.red)
      else $error("steady red network lamp without red module lamp");
   chk_net_single: assert property (!(network_state_lamp_o.red && network_state_lamp_o.green))
      else $error("network lamp red and green together");
   chk_mod_single: assert property (!(module_state_lamp_o.red && module_state_lamp_o.green))
      else $error("module lamp red and green together");
endmodule
bind fbsi_top fbsi_top_monitor #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .link_up_i(link_up_i), .speed_100_i(speed_100_i), .full_duplex_i(full_duplex_i),
   .frame_i(frame_i), .network_state_lamp_o(network_state_lamp_o),
   .module_state_lamp_o(module_state_lamp_o), .link_lamp_o(link_lamp_o));

// ==== fbsi_ctrl_model.sv ====
// Purpose: far side model, ethernet port of the io controller
// Assumes: one clock shared with the block
// Notes: frames come every FRAME_GAP cycles while traffic is asked for
`timescale 1ns/100ps
module fbsi_ctrl_model #(
   parameter int unsigned FRAME_GAP = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_en_i,
   input wire logic [1:0] mode_i,
   input wire logic traffic_i,
   output logic link_up_o,
   output logic speed_100_o,
   output logic full_duplex_o,
   output logic frame_o
);
   int unsigned gap = 0;
   always @(posedge clk_i)
   begin
      link_up_o <= link_en_i & !rst_i;
      // mode bit 1 picks a fast partner, bit 0 a full duplex one
      speed_100_o <= mode_i[1];
      full_duplex_o <= mode_i[0];
      gap <= (rst_i || gap == 0) ? FRAME_GAP - 1 : gap - 1;
      frame_o <= traffic_i && link_en_i && gap == 0;
   end
endmodule

// ==== fbsi_top_tb.sv ====
// Purpose: self-checking bench for the status lamp block
// Assumes: short lamp timing 4,4,12,6,2,10 cycles
// Notes: flash codes are judged by lit cycles over whole periods
`timescale 1ns/100ps
module fbsi_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic ack;
   logic link_en = 1'b0;
   logic [1:0] mode = 2'h3;
   logic traffic = 1'b0;
   logic link_up, speed_100, full_duplex, frame, link_lamp;
   fbsi_pkg::fbsi_lamp_t net_lamp;
   fbsi_pkg::fbsi_lamp_t mod_lamp;
   int errors = 0;
   int n_checks = 0;
   int cnt [5];
   // control word, window, net red, net green, module red, module green
   int tbl [14][6] = '{'{'h0003, 24, 0, 24, 0, 24}, '{'h0001, 40, 0, 8, 0, 40},
      '{'h0007, 40, 0, 8, 0, 40}, '{'h000b, 40, 0, 8, 0, 40}, '{'h0013, 24, 0, 12, 0, 24},
      '{'h0043, 40, 8, 0, 0, 40}, '{'h0083, 56, 16, 0, 0, 56}, '{'h0103, 72, 24, 0, 0, 72},
      '{'h01f3, 24, 24, 0, 24, 0}, '{'h0843, 40, 8, 0, 40, 0}, '{'h1003, 24, 0, 24, 12, 12},
      '{'h0600, 24, 0, 0, 0, 0}, '{'h0403, 24, 0, 24, 0, 0}, '{'h2003, 40, 0, 40, 0, 8}};
   fbsi_top #(.FLASH_ON_CYC(4), .FLASH_OFF_CYC(4), .FLASH_GAP_CYC(12), .BLINK_HALF_CYC(6),
      .FLICKER_HALF_CYC(2), .ACT_HOLD_CYC(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link_up_i(link_up),
      .speed_100_i(speed_100), .full_duplex_i(full_duplex), .frame_i(frame),
      .network_state_lamp_o(net_lamp), .module_state_lamp_o(mod_lamp), .link_lamp_o(link_lamp));
   fbsi_ctrl_model #(.FRAME_GAP(3)) u_far (.clk_i(clk_i), .rst_i(rst_i), .link_en_i(link_en),
      .mode_i(mode), .traffic_i(traffic), .link_up_o(link_up), .speed_100_o(speed_100),
      .full_duplex_o(full_duplex), .frame_o(frame));
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic stop_test();
      if (errors == 0 && n_checks > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // entered just after a rising edge; leaves one idle cycle behind
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
      int i;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (ack !== 1'b1 && i < 20);
      q = rdat;
      if (ack !== 1'b1)
      begin
         errors++;
         stop_test();
      end
      else
      begin
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task automatic watch(input int w);
      cnt = '{default: 0};
      repeat (w)
      begin
         @(posedge clk_i);
         cnt[0] += (net_lamp.red === 1'b1);
         cnt[1] += (net_lamp.green === 1'b1);
         cnt[2] += (mod_lamp.red === 1'b1);
         cnt[3] += (mod_lamp.green === 1'b1);
         cnt[4] += (link_lamp === 1'b1);
      end
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 4'h0, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000600);
      cmp32({27'h0, net_lamp, mod_lamp, link_lamp}, 32'h0);
      wb(1'b0, 4'h4, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00200020);
      wb(1'b1, 4'hc, 4'hf, 32'hffffffff, rd);
      wb(1'b0, 4'hc, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000800);
      wb(1'b0, 4'h6, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000000);
      // one byte over the cap in the output field refuses the whole word
      wb(1'b1, 4'h4, 4'hf, 32'h01010100, rd);
      wb(1'b0, 4'h4, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00200020);
      wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000100);
      wb(1'b1, 4'h4, 4'hf, 32'h01000100, rd);
      wb(1'b0, 4'h4, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h01000100);
      wb(1'b1, 4'h8, 4'h2, 32'h00000100, rd);
      wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000000);
      wb(1'b1, 4'h0, 4'h1, 32'h00000003, rd);
      wb(1'b0, 4'h0, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000603);
      for (int k = 0; k < 14; k++)
      begin
         wb(1'b1, 4'h0, 4'hf, tbl[k][0], rd);
         repeat (3) @(posedge clk_i);
         watch(tbl[k][1]);
         cmp_cnt(cnt[0], tbl[k][2]);
         cmp_cnt(cnt[1], tbl[k][3]);
         cmp_cnt(cnt[2], tbl[k][4]);
         cmp_cnt(cnt[3], tbl[k][5]);
      end
      watch(24);
      cmp_cnt(cnt[4], 0);
      link_en <= 1'b1;
      // slow partner first, then a half duplex one: each counts as no link
      mode <= 2'h1;
      watch(24);
      cmp_cnt(cnt[4], 0);
      wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
      cmp32(rd & 32'h000001e0, 32'h00000040);
      mode <= 2'h2;
      watch(24);
      cmp_cnt(cnt[4], 0);
      mode <= 2'h3;
      repeat (3) @(posedge clk_i);
      watch(24);
      cmp_cnt(cnt[4], 24);
      wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
      cmp32(rd & 32'h000001e0, 32'h00000020);
      traffic <= 1'b1;
      // the first frame may come three cycles late, so settle longer
      repeat (8) @(posedge clk_i);
      watch(24);
      cmp_cnt(cnt[4], 12);
      wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
      cmp32(rd & 32'h000001e0, 32'h000000a0);
      traffic <= 1'b0;
      repeat (16) @(posedge clk_i);
      watch(24);
      cmp_cnt(cnt[4], 24);
      // a second reset must bring back the power-up state
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 4'h0, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00000600);
      wb(1'b0, 4'h4, 4'hf, 32'h0, rd);
      cmp32(rd, 32'h00200020);
      stop_test();
   end
endmodule
